//--- rtl/dsp_core_pkg.sv
// constants and types for the core datapath and status block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dsp_core_pkg;
  localparam int DATA_W     = 16;
  localparam int ACC_W      = 32;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W      = 3;
  // status zero field positions
  localparam int S0_ARP_LSB = 13;
  localparam int S0_OV      = 12;
  localparam int S0_OVM     = 11;
  localparam int S0_RSV     = 10;
  localparam int S0_GLOBAL_IRQ_MASK    = 9;
  localparam int S0_DP_MSB  = 8;
  // status one field positions
  localparam int S1_ARB_LSB = 13;
  localparam int S1_CNF     = 12;
  localparam int S1_TC      = 11;
  localparam int S1_SXM     = 10;
  localparam int S1_C       = 9;
  localparam int S1_XF      = 4;
  localparam int S1_PM_MSB  = 1;
  // reserved bits read as one
  localparam logic [15:0] S0_RSV_MASK = 16'h0400;
  localparam logic [15:0] S1_RSV_MASK = 16'h01ec;
  // reset values: mask, carry and reserved bits set, all else zero
  localparam logic [15:0] S0_RESET = 16'h0600;
  localparam logic [15:0] S1_RESET = 16'h03ec;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // product shift modes
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_L1   = 2'h1;
  localparam logic [1:0] PM_L4   = 2'h2;
  localparam logic [1:0] PM_R6   = 2'h3;
  // address source for next fetch
  typedef enum logic [1:0] {ADDR_SEQ, ADDR_JUMP, ADDR_RET, ADDR_DATA} addr_src_t;
  // status register operations
  typedef enum logic [2:0] {ST_NONE, ST_LOAD0, ST_LOAD1, ST_SETBIT, ST_CLRBIT} st_op_t;
endpackage : dsp_core_pkg

//--- rtl/product_scaler.sv
// product scaling shifter, combinational
`timescale 1ns/1ps
module product_scaler (
  // product in and mode
  input  wire logic [31:0] i_prod,
  input  wire logic [1:0]  i_mode,
  // scaled product
  output logic      [31:0] o_scaled
);
  // select the shift with no added cycle
  always_comb begin
    case (i_mode)
      dsp_core_pkg::PM_L1: o_scaled = {i_prod[30:0], 1'h0};
      dsp_core_pkg::PM_L4: o_scaled = {i_prod[27:0], 4'h0};
      dsp_core_pkg::PM_R6: o_scaled = {{6{i_prod[31]}}, i_prod[31:6]};
      default:             o_scaled = i_prod;
    endcase
  end
endmodule : product_scaler

//--- rtl/output_scaler.sv
// output scaling shifter, combinational
`timescale 1ns/1ps
module output_scaler (
  // accumulator and control
  input  wire logic [31:0] i_acc,
  input  wire logic [2:0]  i_shift,
  input  wire logic        i_high,
  // half word to the write bus
  output logic      [15:0] o_word
);
  logic [31:0] shifted;
  // left shift 0..7 then pick a half
  always_comb begin
    shifted = i_acc << i_shift;
    o_word  = i_high ? shifted[31:16] : shifted[15:0];
  end
endmodule : output_scaler

//--- rtl/dsp_core_datapath_status.sv
// core address generation, scalers, product, temp, stack and status registers
`timescale 1ns/1ps
module dsp_core_datapath_status #(
  parameter int STACK_DEPTH = dsp_core_pkg::STACK_DEPTH
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // address generation control from decoder
  input  wire logic        i_bus_stall,
  input  wire dsp_core_pkg::addr_src_t i_addr_src,
  input  wire logic [15:0] i_jump_addr,
  input  wire logic [15:0] i_data_addr,
  input  wire logic        i_data_seq_start,
  input  wire logic        i_data_seq_end,
  // return stack
  input  wire logic        i_push,
  input  wire logic        i_push_data,
  input  wire logic [15:0] i_push_word,
  input  wire logic        i_pop,
  // multiply and temp
  input  wire logic        i_temp_operand_register_load,
  input  wire logic [15:0] i_temp_operand_register_word,
  input  wire logic        i_prod_load,
  input  wire logic [31:0] i_mult_result,
  // output scaler
  input  wire logic [31:0] i_acc,
  input  wire logic [2:0]  i_out_shift,
  input  wire logic        i_out_high,
  // status control
  input  wire dsp_core_pkg::st_op_t i_st_op,
  input  wire logic [15:0] i_st_word,
  input  wire logic [3:0]  i_st_bit,
  input  wire logic        i_st_sel,
  input  wire logic        i_arp_load,
  input  wire logic [2:0]  i_arp_value,
  input  wire logic        i_dp_load,
  input  wire logic [8:0]  i_dp_value,
  input  wire logic        i_alu_ovf,
  input  wire logic        i_ovf_branch,
  input  wire logic        i_irq_taken,
  input  wire logic        i_carry_we,
  input  wire logic        i_carry_in,
  input  wire logic        i_tc_we,
  input  wire logic        i_tc_in,
  // condition query
  input  wire logic [2:0]  i_cond_sel,
  // address buses
  output logic [15:0] o_prog_addr,
  output logic [15:0] o_next_addr,
  // data and operands
  output logic [15:0] o_write_word,
  output logic [15:0] o_status_word,
  output logic [31:0] o_prod_scaled,
  output logic [15:0] o_mult_operand,
  output logic [3:0]  o_shift_count,
  output logic [3:0]  o_bit_index,
  output logic [15:0] o_stack_top,
  output logic [3:0]  o_stack_level,
  // status
  output logic [15:0] o_status_zero,
  output logic [15:0] o_status_one,
  output logic        o_cond_true
);
  // --------------------------------------------------------------------------
  // address generation
  // --------------------------------------------------------------------------
  logic [15:0] next_prog_addr_reg_r, next_prog_addr_reg_nxt;
  logic [15:0] par_r;
  logic [15:0] micro_r;
  logic        micro_busy_r;
  logic [15:0] pc_inc;
  logic [15:0] stack_r [STACK_DEPTH];
  logic [3:0]  sp_r;

  assign pc_inc = next_prog_addr_reg_r + 16'h0001;

  // next address selection
  always_comb begin
    next_prog_addr_reg_nxt = next_prog_addr_reg_r;
    if (!i_bus_stall) begin
      if (i_data_seq_end && micro_busy_r) begin
        next_prog_addr_reg_nxt = micro_r;
      end else begin
        case (i_addr_src)
          dsp_core_pkg::ADDR_JUMP: next_prog_addr_reg_nxt = i_jump_addr;
          dsp_core_pkg::ADDR_RET:  next_prog_addr_reg_nxt = stack_r[0];
          dsp_core_pkg::ADDR_DATA: next_prog_addr_reg_nxt = i_data_addr;
          default:                 next_prog_addr_reg_nxt = pc_inc;
        endcase
      end
    end
  end

  // next and current address registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      next_prog_addr_reg_r <= dsp_core_pkg::PC_RESET;
      par_r  <= dsp_core_pkg::PC_RESET;
    end else if (!i_bus_stall) begin
      par_r  <= next_prog_addr_reg_r;
      next_prog_addr_reg_r <= next_prog_addr_reg_nxt;
    end
  end

  // micro store for borrowed address logic
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      micro_r      <= 16'h0000;
      micro_busy_r <= 1'b0;
    end else if (!i_bus_stall) begin
      if (i_data_seq_start && !micro_busy_r) begin
        micro_r      <= pc_inc;
        micro_busy_r <= 1'b1;
      end else if (i_data_seq_end) begin
        micro_busy_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // return stack, top at entry 0
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_r <= 4'h0;
    end else if (i_push && !i_pop) begin
      sp_r <= (sp_r == 4'(STACK_DEPTH)) ? sp_r : sp_r + 4'h1;
    end else if (i_pop && !i_push) begin
      sp_r <= (sp_r == 4'h0) ? sp_r : sp_r - 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
      logic [15:0] above;
      logic [15:0] below;
      // neighbours chosen at elaboration so no index leaves the array
      if (gi == 0) begin : g_head
        assign above = i_push_data ? i_push_word : next_prog_addr_reg_r;
      end else begin : g_inner
        assign above = stack_r[gi-1];
      end
      if (gi == STACK_DEPTH-1) begin : g_tail
        assign below = stack_r[gi];
      end else begin : g_upper
        assign below = stack_r[gi+1];
      end
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          stack_r[gi] <= 16'h0000;
        end else if (i_push) begin
          stack_r[gi] <= above;
        end else if (i_pop) begin
          stack_r[gi] <= below;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // product and temp registers
  // --------------------------------------------------------------------------
  logic [31:0] product_register_r;
  logic [15:0] temp_operand_register_r;
  logic [31:0] prod_scaled;
  logic [15:0] write_word;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      product_register_r <= 32'h0000_0000;
      temp_operand_register_r <= 16'h0000;
    end else begin
      if (i_prod_load) product_register_r <= i_mult_result;
      if (i_temp_operand_register_load) temp_operand_register_r <= i_temp_operand_register_word;
    end
  end

  // --------------------------------------------------------------------------
  // status registers
  // --------------------------------------------------------------------------
  logic [15:0] st0_r, st1_r;
  logic [15:0] st0_nxt, st1_nxt;

  // status next value
  always_comb begin
    st0_nxt = st0_r;
    st1_nxt = st1_r;
    if (i_alu_ovf) st0_nxt[dsp_core_pkg::S0_OV] = 1'b1;
    else if (i_ovf_branch) st0_nxt[dsp_core_pkg::S0_OV] = 1'b0;
    if (i_carry_we) st1_nxt[dsp_core_pkg::S1_C] = i_carry_in;
    if (i_tc_we) st1_nxt[dsp_core_pkg::S1_TC] = i_tc_in;
    if (i_dp_load) st0_nxt[dsp_core_pkg::S0_DP_MSB:0] = i_dp_value;
    if (i_arp_load) begin
      st0_nxt[15:dsp_core_pkg::S0_ARP_LSB] = i_arp_value;
      st1_nxt[15:dsp_core_pkg::S1_ARB_LSB] = st0_r[15:dsp_core_pkg::S0_ARP_LSB];
    end
    case (i_st_op)
      dsp_core_pkg::ST_LOAD0: begin
        st0_nxt = {i_st_word[15:10], st0_r[dsp_core_pkg::S0_GLOBAL_IRQ_MASK], i_st_word[8:0]};
      end
      dsp_core_pkg::ST_LOAD1: begin
        st1_nxt = i_st_word;
        st0_nxt[15:dsp_core_pkg::S0_ARP_LSB] = i_st_word[15:13];
      end
      dsp_core_pkg::ST_SETBIT: begin
        if (i_st_sel) st1_nxt[i_st_bit] = 1'b1;
        else st0_nxt[i_st_bit] = 1'b1;
      end
      dsp_core_pkg::ST_CLRBIT: begin
        if (i_st_sel) st1_nxt[i_st_bit] = 1'b0;
        else st0_nxt[i_st_bit] = 1'b0;
      end
      default: ;
    endcase
    if (i_irq_taken) st0_nxt[dsp_core_pkg::S0_GLOBAL_IRQ_MASK] = 1'b1;
    st0_nxt = st0_nxt | dsp_core_pkg::S0_RSV_MASK;
    st1_nxt = st1_nxt | dsp_core_pkg::S1_RSV_MASK;
  end

  // status registers with layout constants
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st0_r <= dsp_core_pkg::S0_RESET;
      st1_r <= dsp_core_pkg::S1_RESET;
    end else begin
      st0_r <= st0_nxt;
      st1_r <= st1_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // scalers
  // --------------------------------------------------------------------------
  product_scaler u_product_scaler (
    .i_prod   (product_register_r),
    .i_mode   (st1_r[dsp_core_pkg::S1_PM_MSB:0]),
    .o_scaled (prod_scaled)
  );

  output_scaler u_output_scaler (
    .i_acc   (i_acc),
    .i_shift (i_out_shift),
    .i_high  (i_out_high),
    .o_word  (write_word)
  );

  // --------------------------------------------------------------------------
  // condition evaluation
  // --------------------------------------------------------------------------
  logic cond;
  always_comb begin
    case (i_cond_sel)
      3'h0:    cond = st0_r[dsp_core_pkg::S0_OV];
      3'h1:    cond = !st0_r[dsp_core_pkg::S0_OV];
      3'h2:    cond = st1_r[dsp_core_pkg::S1_C];
      3'h3:    cond = !st1_r[dsp_core_pkg::S1_C];
      3'h4:    cond = st1_r[dsp_core_pkg::S1_TC];
      3'h5:    cond = !st1_r[dsp_core_pkg::S1_TC];
      default: cond = 1'b1;
    endcase
  end

  // registered outputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_write_word   <= 16'h0000;
      o_status_word  <= 16'h0000;
      o_prod_scaled  <= 32'h0000_0000;
      o_cond_true    <= 1'b0;
    end else begin
      o_write_word   <= write_word;
      o_status_word  <= i_st_sel ? st1_r : st0_r;
      o_prod_scaled  <= prod_scaled;
      o_cond_true    <= cond;
    end
  end

  assign o_prog_addr    = par_r;
  assign o_next_addr    = next_prog_addr_reg_r;
  assign o_mult_operand = temp_operand_register_r;
  assign o_shift_count  = temp_operand_register_r[3:0];
  assign o_bit_index    = temp_operand_register_r[3:0];
  assign o_stack_top    = stack_r[0];
  assign o_stack_level  = sp_r;
  assign o_status_zero  = st0_r;
  assign o_status_one   = st1_r;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_par_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_bus_stall |=> par_r == $past(next_prog_addr_reg_r)) else $error("par did not take next address");
  a_par_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus_stall |=> $stable(par_r)) else $error("par moved during stall");
  a_pc_incr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_bus_stall && i_addr_src == dsp_core_pkg::ADDR_SEQ && !i_data_seq_end)
    |=> next_prog_addr_reg_r == $past(next_prog_addr_reg_r) + 16'h0001) else $error("sequential address wrong");
  a_rsv_ones: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st0_r[10] && (st1_r & 16'h01ec) == 16'h01ec)) else $error("reserved bit read zero");
  a_global_irq_mask_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_st_op == dsp_core_pkg::ST_LOAD0 && !i_irq_taken) |=> st0_r[9] == $past(st0_r[9]))
    else $error("status load changed mask");
  a_ov_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_alu_ovf |=> st0_r[12]) else $error("overflow not latched");
  a_irq_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_irq_taken |=> st0_r[9]) else $error("mask not set on interrupt");
  a_arb_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_arp_load && i_st_op == dsp_core_pkg::ST_NONE) |=> st1_r[15:13] == $past(st0_r[15:13]))
    else $error("pointer buffer not copied");
  a_prod_cap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_prod_load |=> product_register_r == $past(i_mult_result)) else $error("product not captured");
  c_stall: cover property (@(posedge i_clk) disable iff (i_sys_rst) i_bus_stall [*3]);
  c_borrow: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_data_seq_start ##[1:8] i_data_seq_end);
  c_stack_full: cover property (@(posedge i_clk) disable iff (i_sys_rst) sp_r == 4'h8);
endmodule : dsp_core_datapath_status

//--- dv/mem_wait_model.sv
// memory bus model that adds wait states after each new program address
`timescale 1ns/1ps
module mem_wait_model (
  // clock, reset and wait count
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [1:0]  i_waits,
  // address from the core
  input  wire logic [15:0] i_prog_addr,
  // stall back to the core
  output logic             o_stall
);
  logic [15:0] last_r;
  logic [1:0]  cnt_r;
  // start a wait burst whenever the bus shows a new address
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_r <= 16'h0000;
      cnt_r  <= 2'h0;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end else if (i_prog_addr != last_r) begin
      last_r <= i_prog_addr;
      cnt_r  <= i_waits;
    end
  end
  assign o_stall = (cnt_r != 2'h0); // memory not done yet
endmodule : mem_wait_model

//--- dv/tb_top.sv
// self-checking bench for the core datapath and status block
`timescale 1ns/1ps
module tb_top;
  // design inputs
  logic i_clk, i_sys_rst, i_bus_stall, i_data_seq_start, i_data_seq_end, i_push, i_push_data, i_pop;
  logic i_temp_operand_register_load, i_prod_load, i_out_high, i_st_sel, i_arp_load, i_dp_load, i_alu_ovf;
  logic i_ovf_branch, i_irq_taken, i_carry_we, i_carry_in, i_tc_we, i_tc_in;
  logic [15:0] i_jump_addr, i_data_addr, i_push_word, i_temp_operand_register_word, i_st_word;
  logic [31:0] i_mult_result, i_acc;
  logic [2:0]  i_out_shift, i_arp_value, i_cond_sel;
  logic [3:0]  i_st_bit;
  logic [8:0]  i_dp_value;
  logic [1:0]  waits;
  dsp_core_pkg::addr_src_t i_addr_src;
  dsp_core_pkg::st_op_t    i_st_op;
  // design outputs
  logic [15:0] o_prog_addr, o_next_addr, o_write_word, o_status_word, o_mult_operand, o_stack_top;
  logic [15:0] o_status_zero, o_status_one;
  logic [31:0] o_prod_scaled;
  logic [3:0]  o_shift_count, o_bit_index, o_stack_level;
  logic        o_cond_true;
  // bench state
  int          errors, checks_done, seed, i;
  logic [15:0] m0, m1, w, p, n;
  logic [15:0] stk [9];
  logic [31:0] r;
  logic        s;

  dsp_core_datapath_status dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus_stall(i_bus_stall),
    .i_addr_src(i_addr_src), .i_jump_addr(i_jump_addr), .i_data_addr(i_data_addr),
    .i_data_seq_start(i_data_seq_start), .i_data_seq_end(i_data_seq_end), .i_push(i_push),
    .i_push_data(i_push_data), .i_push_word(i_push_word), .i_pop(i_pop), .i_temp_operand_register_load(i_temp_operand_register_load),
    .i_temp_operand_register_word(i_temp_operand_register_word), .i_prod_load(i_prod_load), .i_mult_result(i_mult_result), .i_acc(i_acc),
    .i_out_shift(i_out_shift), .i_out_high(i_out_high), .i_st_op(i_st_op), .i_st_word(i_st_word),
    .i_st_bit(i_st_bit), .i_st_sel(i_st_sel), .i_arp_load(i_arp_load), .i_arp_value(i_arp_value),
    .i_dp_load(i_dp_load), .i_dp_value(i_dp_value), .i_alu_ovf(i_alu_ovf), .i_ovf_branch(i_ovf_branch),
    .i_irq_taken(i_irq_taken), .i_carry_we(i_carry_we), .i_carry_in(i_carry_in), .i_tc_we(i_tc_we),
    .i_tc_in(i_tc_in), .i_cond_sel(i_cond_sel), .o_prog_addr(o_prog_addr), .o_next_addr(o_next_addr),
    .o_write_word(o_write_word), .o_status_word(o_status_word), .o_prod_scaled(o_prod_scaled),
    .o_mult_operand(o_mult_operand), .o_shift_count(o_shift_count), .o_bit_index(o_bit_index),
    .o_stack_top(o_stack_top), .o_stack_level(o_stack_level), .o_status_zero(o_status_zero),
    .o_status_one(o_status_one), .o_cond_true(o_cond_true));
  mem_wait_model mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_waits(waits), .i_prog_addr(o_prog_addr),
    .o_stall(i_bus_stall));

  // 200 mhz core clock
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  // expected scaled product for a shift mode
  function automatic logic [31:0] f_prod(logic [31:0] v, logic [1:0] m);
    case (m)
      2'h0: return v;
      2'h1: return v << 1;
      2'h2: return v << 4;
      default: return $signed(v) >>> 6;
    endcase
  endfunction : f_prod
  // expected half word from the output scaler
  function automatic logic [15:0] f_out(logic [31:0] a, logic [2:0] k, logic h);
    logic [31:0] t;
    t = a << k;
    return h ? t[31:16] : t[15:0];
  endfunction : f_out
  // expected condition from the model status
  function automatic logic f_cond(logic [2:0] c);
    case (c)
      3'h0: return m0[12];
      3'h1: return !m0[12];
      3'h2: return m1[9];
      3'h3: return !m1[9];
      3'h4: return m1[11];
      3'h5: return !m1[11];
      default: return 1'b1;
    endcase
  endfunction : f_cond

  // one edge: drop the load, stack and status pulses, not i_data_seq_start or i_data_seq_end, then let outputs settle
  task automatic tick();
    @(posedge i_clk);
    {i_push, i_pop, i_temp_operand_register_load, i_prod_load, i_arp_load, i_dp_load} <= '0;
    {i_alu_ovf, i_ovf_branch, i_irq_taken, i_carry_we, i_tc_we} <= '0;
    i_st_op <= dsp_core_pkg::ST_NONE;
    #1;
  endtask : tick
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk32
  task automatic chks();
    chk16("status zero", m0, o_status_zero);
    chk16("status one", m1, o_status_one);
  endtask : chks
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // watchdog against a hang
  initial begin
    #20000;
    errors++;
    complete_run();
  end

  // main sequence
  initial begin
    seed = 32'h411e;
    errors = 0;
    checks_done = 0;
    {i_data_seq_start, i_data_seq_end, i_push, i_push_data, i_pop, i_temp_operand_register_load, i_prod_load} = '0;
    {i_out_high, i_st_sel, i_arp_load, i_dp_load, i_alu_ovf, i_ovf_branch, i_irq_taken} = '0;
    {i_carry_we, i_carry_in, i_tc_we, i_tc_in, i_jump_addr, i_data_addr, i_push_word} = '0;
    {i_temp_operand_register_word, i_st_word, i_mult_result, i_acc, i_out_shift, i_arp_value, i_cond_sel} = '0;
    {i_st_bit, i_dp_value, waits} = '0;
    i_addr_src = dsp_core_pkg::ADDR_SEQ;
    i_st_op = dsp_core_pkg::ST_NONE;
    i_sys_rst = 1'b1;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    m0 = 16'h0600; // mask set, reserved one
    m1 = 16'h03ec; // carry set, reserved ones
    chks();
    chk16("prog addr", 16'h0000, o_prog_addr);
    // sequential fetch with wait states
    waits = 2'h2;
    repeat (30) begin
      s = i_bus_stall;
      p = o_prog_addr;
      n = o_next_addr;
      tick();
      if (s) begin
        chk16("par hold", p, o_prog_addr);
        chk16("next_prog_addr_reg hold", n, o_next_addr);
      end else begin
        chk16("par", n, o_prog_addr);
        chk16("next_prog_addr_reg", n + 16'h1, o_next_addr);
      end
    end
    waits = 2'h0;
    repeat (3) tick();
    r = $random(seed);
    i_jump_addr <= r[15:0];
    i_addr_src <= dsp_core_pkg::ADDR_JUMP;
    tick();
    i_addr_src <= dsp_core_pkg::ADDR_SEQ;
    chk16("jump", r[15:0], o_next_addr);
    // borrowed address logic, then a return through the stack
    n = o_next_addr;
    w = $random(seed);
    i_addr_src <= dsp_core_pkg::ADDR_DATA;
    i_data_addr <= w;
    i_data_seq_start <= 1'b1;
    tick();
    i_addr_src <= dsp_core_pkg::ADDR_SEQ;
    i_data_seq_start <= 1'b0;
    chk16("data addr", w, o_next_addr);
    tick();
    chk16("data seq", w + 16'h1, o_next_addr);
    i_data_seq_end <= 1'b1;
    tick();
    i_data_seq_end <= 1'b0;
    chk16("restore", n + 16'h1, o_next_addr);
    n = o_next_addr;
    i_push <= 1'b1;
    i_push_data <= 1'b0;
    tick();
    chk16("ret push", n, o_stack_top);
    i_addr_src <= dsp_core_pkg::ADDR_RET;
    i_pop <= 1'b1;
    tick();
    i_addr_src <= dsp_core_pkg::ADDR_SEQ;
    chk16("return", n, o_next_addr);
    // status loads and stores
    repeat (4) begin
      w = $random(seed);
      i_st_op <= dsp_core_pkg::ST_LOAD0;
      i_st_word <= w;
      tick();
      m0 = (w & 16'hfdff) | (m0 & 16'h0200) | 16'h0400;
      chks();
      w = $random(seed);
      i_st_op <= dsp_core_pkg::ST_LOAD1;
      i_st_word <= w;
      tick();
      m1 = w | 16'h01ec;
      m0[15:13] = w[15:13];
      chks();
      for (i = 0; i < 2; i++) begin
        i_st_sel <= i[0];
        tick();
        chk16("store", i[0] ? m1 : m0, o_status_word);
      end
    end
    // single bit set and clear
    repeat (12) begin
      s = $random(seed);
      i = {$random(seed)} % 13;
      r = $random(seed);
      i_st_op <= s ? dsp_core_pkg::ST_SETBIT : dsp_core_pkg::ST_CLRBIT;
      i_st_bit <= i[3:0];
      i_st_sel <= r[0];
      tick();
      if (r[0]) m1[i] = s;
      else m0[i] = s;
      m0 = m0 | 16'h0400;
      m1 = m1 | 16'h01ec;
      chks();
    end
    i_st_op <= dsp_core_pkg::ST_CLRBIT;
    i_st_bit <= 4'h9;
    i_st_sel <= 1'b0;
    tick();
    m0[9] = 1'b0;
    i_irq_taken <= 1'b1;
    tick();
    m0[9] = 1'b1;
    chks();
    // field updates and condition codes
    repeat (6) begin
      r = $random(seed);
      {i_arp_load, i_dp_load, i_carry_we, i_tc_we} <= 4'hf;
      i_arp_value <= r[2:0];
      i_dp_value <= r[11:3];
      i_carry_in <= r[12];
      i_tc_in <= r[13];
      i_alu_ovf <= r[14];
      tick();
      m1[15:13] = m0[15:13];
      m0[15:13] = r[2:0];
      m0[8:0] = r[11:3];
      m1[9] = r[12];
      m1[11] = r[13];
      if (r[14]) m0[12] = 1'b1;
      chks();
      for (i = 0; i < 8; i++) begin
        i_cond_sel <= i[2:0];
        tick();
        chk16("cond", {15'h0, f_cond(i[2:0])}, {15'h0, o_cond_true});
      end
    end
    i_alu_ovf <= 1'b1;
    tick();
    m0[12] = 1'b1;
    repeat (3) tick();
    chks();
    i_ovf_branch <= 1'b1;
    tick();
    m0[12] = 1'b0;
    chks();
    // return stack overfill and drain
    for (i = 0; i < 9; i++) begin
      stk[i] = $random(seed);
      {i_push, i_push_data} <= 2'h3;
      i_push_word <= stk[i];
      tick();
    end
    chk16("level", 16'h0008, {12'h0, o_stack_level});
    for (i = 8; i > 0; i--) begin
      chk16("top", stk[i], o_stack_top);
      i_pop <= 1'b1;
      tick();
    end
    chk16("level", 16'h0000, {12'h0, o_stack_level});
    i_pop <= 1'b1;
    tick();
    chk16("level", 16'h0000, {12'h0, o_stack_level});
    // operands, product modes and output scaling
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      w = $random(seed);
      w[1:0] = i[1:0];
      {i_temp_operand_register_load, i_prod_load} <= 2'h3;
      i_temp_operand_register_word <= r[15:0];
      i_mult_result <= r;
      i_st_op <= dsp_core_pkg::ST_LOAD1;
      i_st_word <= w;
      i_acc <= r;
      i_out_shift <= w[15:13];
      i_out_high <= w[4];
      tick();
      m1 = w | 16'h01ec;
      m0[15:13] = w[15:13];
      chk16("write", f_out(r, w[15:13], w[4]), o_write_word);
      chk16("temp_operand_register", r[15:0], o_mult_operand);
      chk16("count", {12'h0, r[3:0]}, {12'h0, o_shift_count});
      chk16("bit index", {12'h0, r[3:0]}, {12'h0, o_bit_index});
      tick();
      chk32("product", f_prod(r, w[1:0]), o_prod_scaled);
      chks();
    end
    complete_run();
  end
endmodule : tb_top
